// ===== tpm_pkg.sv
package tpm_pkg;

    // Clock and timing.
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned SLOT_MS       = 3500;
    localparam int unsigned PASS_MS       = 14000;
    localparam int unsigned DISP_MS       = 1700;
    localparam int unsigned RETRY_WAIT_MS = 5000;
    localparam int unsigned SLOT_CYC_DEF  = SLOT_MS * CYC_PER_MS;
    localparam int unsigned DISP_CYC_DEF  = DISP_MS * CYC_PER_MS;
    localparam int unsigned WAIT_CYC_DEF  = RETRY_WAIT_MS * CYC_PER_MS;
    localparam int unsigned CNT_W         = 32;

    // Colours and sequence limits.
    localparam int unsigned NCOL           = 4;
    localparam logic [1:0]  FIRST_COL      = 2'h0;
    localparam logic [1:0]  LAST_COL       = 2'h3;
    localparam logic [1:0]  STREAK_PRESENT = 2'h3;
    localparam logic [1:0]  ATTEMPTS_MAX   = 2'h3;
    localparam logic [1:0]  ONE2           = 2'h1;

    typedef enum logic [3:0] {
        TPM_IDLE  = 4'h1,
        TPM_DISP  = 4'h2,
        TPM_WAIT  = 4'h4,
        TPM_CHECK = 4'h8
    } tpm_seq_e;

    // Per-colour sensor and reader pins, bit index is the colour.
    typedef struct packed {
        logic [NCOL-1:0] toner;
        logic [NCOL-1:0] actuator;
        logic [NCOL-1:0] read_ok;
        logic [NCOL-1:0] usage_empty;
        logic [NCOL-1:0] disp_zero;
    } tpm_pins_s;

    typedef struct packed {
        logic [NCOL-1:0] replace_colour;
        logic            replace_general;
        logic [NCOL-1:0] remove_seal;
    } tpm_err_s;

    localparam int unsigned SYNC_W = $bits(tpm_pins_s) + 2;

endpackage : tpm_pkg

// ===== tpm_sync.sv
`timescale 1ns/1ps
module tpm_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // Data.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule : tpm_sync

// ===== tpm_monitor.sv
`timescale 1ns/1ps
module tpm_monitor
    import tpm_pkg::*;
#(
    parameter int unsigned SLOT_CYC = SLOT_CYC_DEF,
    parameter int unsigned DISP_CYC = DISP_CYC_DEF,
    parameter int unsigned WAIT_CYC = WAIT_CYC_DEF
) (
    // Clock and reset.
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    // Cartridge pins and engine state.
    input  wire tpm_pins_s       pins,
    input  wire logic            door_closed,
    input  wire logic            print_active,
    // Motors and status.
    output logic      [NCOL-1:0] dispense_motor,
    output tpm_err_s             err,
    output logic      [NCOL-1:0] toner_present,
    output logic      [NCOL-1:0] cart_fitted,
    output logic                 check_busy,
    output logic                 sample_stb,
    output logic      [1:0]      sample_col
);

    tpm_pins_s        pins_s;
    logic             door_s;
    logic             print_s;
    logic             door_q_r;
    logic             pwrup_r;
    logic             start;
    logic [CNT_W-1:0] slot_cnt_r;
    logic [1:0]       idx_r;
    tpm_seq_e         seq_r    [NCOL];
    logic [CNT_W-1:0] cnt_r    [NCOL];
    logic [1:0]       att_r    [NCOL];
    logic [1:0]       streak_r [NCOL];
    logic [NCOL-1:0]  fitted_nxt;
    logic [NCOL-1:0]  fresh;
    logic [NCOL-1:0]  hit;
    logic [NCOL-1:0]  found;
    logic [NCOL-1:0]  miss;
    logic [NCOL-1:0]  seal_set;
    logic [NCOL-1:0]  busy;
    logic [NCOL-1:0]  gen_hit;
    logic             clr_all;
    logic             gen_set;

    tpm_sync #(.W(SYNC_W)) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     ({pins, door_closed, print_active}),
        .dout    ({pins_s, door_s, print_s})
    );

    assign start      = pwrup_r | (door_s & ~door_q_r);
    assign fitted_nxt = pins_s.actuator & pins_s.read_ok;
    assign fresh      = fitted_nxt & ~cart_fitted;

    always_comb begin
        for (int c = 0; c < NCOL; c++) begin
            hit[c]      = sample_stb && (sample_col == c[1:0]);
            found[c]    = hit[c] && (seq_r[c] == TPM_CHECK) && pins_s.toner[c];
            miss[c]     = hit[c] && (seq_r[c] == TPM_CHECK) && !pins_s.toner[c];
            seal_set[c] = miss[c] && (att_r[c] == ATTEMPTS_MAX) && pins_s.disp_zero[c];
            busy[c]     = (seq_r[c] != TPM_IDLE);
            gen_hit[c]  = hit[c] && !busy[c] && cart_fitted[c] && !pins_s.toner[c];
        end
        clr_all = |found;
        gen_set = |gen_hit;
    end

    // Power-up and door edge detection.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pwrup_r  <= 1'b1;
            door_q_r <= 1'b0;
        end else begin
            pwrup_r  <= 1'b0;
            door_q_r <= door_s;
        end
    end

    // Slot timer and colour rotation.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            check_busy <= 1'b0;
            slot_cnt_r <= '0;
            idx_r      <= FIRST_COL;
            sample_stb <= 1'b0;
            sample_col <= FIRST_COL;
        end else begin
            sample_stb <= 1'b0;
            if (start) begin
                check_busy <= 1'b1;
                slot_cnt_r <= '0;
                idx_r      <= FIRST_COL;
            end else if (check_busy || print_s || (|busy)) begin
                check_busy <= 1'b1;
                if (slot_cnt_r == CNT_W'(SLOT_CYC - 1)) begin
                    slot_cnt_r <= '0;
                    idx_r      <= idx_r + ONE2;
                    sample_stb <= 1'b1;
                    sample_col <= idx_r;
                    if (idx_r == LAST_COL && !print_s && !(|busy)) begin
                        check_busy <= 1'b0;
                    end
                end else begin
                    slot_cnt_r <= slot_cnt_r + CNT_W'(1);
                end
            end
        end
    end

    // Per-colour dispense and recheck sequencers.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < NCOL; c++) begin
                seq_r[c]    <= TPM_IDLE;
                cnt_r[c]    <= '0;
                att_r[c]    <= '0;
                streak_r[c] <= '0;
            end
            dispense_motor <= '0;
        end else begin
            for (int c = 0; c < NCOL; c++) begin
                if (!fitted_nxt[c]) begin
                    seq_r[c]          <= TPM_IDLE;
                    dispense_motor[c] <= 1'b0;
                end else begin
                    case (seq_r[c])
                        TPM_IDLE: begin
                            if (fresh[c] && !err.replace_general) begin
                                seq_r[c]          <= TPM_DISP;
                                cnt_r[c]          <= '0;
                                att_r[c]          <= ONE2;
                                streak_r[c]       <= '0;
                                dispense_motor[c] <= 1'b1;
                            end
                        end
                        TPM_DISP: begin
                            if (cnt_r[c] == CNT_W'(DISP_CYC - 1)) begin
                                seq_r[c]          <= TPM_CHECK;
                                cnt_r[c]          <= '0;
                                dispense_motor[c] <= 1'b0;
                            end else begin
                                cnt_r[c] <= cnt_r[c] + CNT_W'(1);
                            end
                        end
                        TPM_CHECK: begin
                            if (found[c]) begin
                                streak_r[c] <= streak_r[c] + ONE2;
                                if (streak_r[c] == STREAK_PRESENT - ONE2) begin
                                    seq_r[c] <= TPM_IDLE;
                                end else begin
                                    seq_r[c]          <= TPM_DISP;
                                    dispense_motor[c] <= 1'b1;
                                end
                            end else if (miss[c]) begin
                                streak_r[c] <= '0;
                                if (att_r[c] == ATTEMPTS_MAX) begin
                                    seq_r[c] <= TPM_IDLE;
                                end else begin
                                    seq_r[c] <= TPM_WAIT;
                                end
                            end
                        end
                        TPM_WAIT: begin
                            if (cnt_r[c] == CNT_W'(WAIT_CYC - 1)) begin
                                seq_r[c]          <= TPM_DISP;
                                cnt_r[c]          <= '0;
                                att_r[c]          <= att_r[c] + ONE2;
                                dispense_motor[c] <= 1'b1;
                            end else begin
                                cnt_r[c] <= cnt_r[c] + CNT_W'(1);
                            end
                        end
                        default: begin
                            seq_r[c]          <= TPM_IDLE;
                            dispense_motor[c] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Fitted and toner-present status.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cart_fitted   <= '0;
            toner_present <= '0;
        end else begin
            cart_fitted <= fitted_nxt;
            for (int c = 0; c < NCOL; c++) begin
                if (!fitted_nxt[c] || gen_hit[c] || miss[c]) begin
                    toner_present[c] <= 1'b0;
                end else if (found[c] && streak_r[c] == STREAK_PRESENT - ONE2) begin
                    toner_present[c] <= 1'b1;
                end
            end
        end
    end

    // Error flags; a set in the same cycle as a clear wins.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            err <= '0;
        end else begin
            err.replace_colour  <= (err.replace_colour & ~{NCOL{clr_all}}) | pins_s.usage_empty;
            err.replace_general <= (err.replace_general & ~clr_all) | gen_set;
            err.remove_seal     <= (err.remove_seal & ~{NCOL{clr_all}}) | seal_set;
        end
    end

    // Helper state for the checks below.
    logic [CNT_W-1:0] disp_len_r;
    logic [1:0]       last_col_r;
    logic             restarted_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            disp_len_r  <= '0;
            last_col_r  <= LAST_COL;
            restarted_r <= 1'b1;
        end else begin
            disp_len_r <= dispense_motor[0] ? disp_len_r + CNT_W'(1) : '0;
            if (start) begin
                restarted_r <= 1'b1;
            end else if (sample_stb) begin
                restarted_r <= 1'b0;
                last_col_r  <= sample_col;
            end
        end
    end

    sample_gap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_stb |=> !sample_stb) else $error("sample strobe longer than one cycle");
    rotate_order_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_stb && !restarted_r && !start |-> sample_col == last_col_r + ONE2)
        else $error("colour rotation out of order");
    restart_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        start |=> idx_r == FIRST_COL && check_busy) else $error("check did not restart at first colour");
    fitted_combo_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cart_fitted[0] |-> $past(pins_s.actuator[0] && pins_s.read_ok[0]))
        else $error("fitted without actuator and read");
    disp_length_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(dispense_motor[0]) && cart_fitted[0] |-> disp_len_r == CNT_W'(DISP_CYC))
        else $error("dispense length wrong");
    clear_all_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clr_all && !gen_set && !(|seal_set) |=> !err.replace_general && err.remove_seal == '0)
        else $error("errors not cleared after toner found");
    general_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        gen_set |=> err.replace_general) else $error("general replace error missing");
    colour_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pins_s.usage_empty[1] |=> err.replace_colour[1]) else $error("colour replace error missing");
    seal_err_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        seal_set[2] |=> err.remove_seal[2] && seq_r[2] == TPM_IDLE) else $error("seal error missing");
    present_streak_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(toner_present[0]) |-> $past(found[0] && streak_r[0] == STREAK_PRESENT - ONE2))
        else $error("present without three finds");
    retry_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        miss[2] && fitted_nxt[2] && att_r[2] != ATTEMPTS_MAX |=> seq_r[2] == TPM_WAIT && !dispense_motor[2])
        else $error("no wait after failed dispense");

    dispense_cover: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(dispense_motor[0]));
    present_cover: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(toner_present[0]));
    seal_cover: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(err.remove_seal[2]));
    general_cover: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(err.replace_general));

endmodule : tpm_monitor

// ===== tpm_cart_model.sv
`timescale 1ns/1ps
module tpm_cart_model
    import tpm_pkg::*;
(
    // Clock and reset.
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    // Cartridge set-up from the bench.
    input  wire logic [NCOL-1:0] fit,
    input  wire logic [NCOL-1:0] mem_ok,
    input  wire logic [NCOL-1:0] spent,
    input  wire logic [NCOL-1:0] full,
    input  wire logic [NCOL-1:0] seal,
    // Motors and sensor pins.
    input  wire logic [NCOL-1:0] motor,
    output tpm_pins_s            pins
);
    logic [NCOL-1:0] primed_r;

    // Toner reaches the sensor only once the auger has turned.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            primed_r <= '0;
        end else begin
            primed_r <= (primed_r | motor) & fit;
        end
    end

    // A sealed cartridge never dispensed, so its dispense time stays zero.
    assign pins.toner       = primed_r & full & ~seal & fit;
    assign pins.actuator    = fit;
    assign pins.read_ok     = mem_ok & fit;
    assign pins.usage_empty = spent;
    assign pins.disp_zero   = seal;
endmodule : tpm_cart_model

// ===== test_toner_presence_monitor.sv
`timescale 1ns/1ps
module test_toner_presence_monitor;
    import tpm_pkg::*;
    localparam int unsigned SLOT = 40;
    localparam int unsigned DISP = 8;
    localparam int unsigned WAIT = 12;
    logic            clk_sys, rstn, door_closed, print_active, check_busy, sample_stb;
    logic [NCOL-1:0] fit, mem_ok, spent, full, seal, dispense_motor, toner_present, cart_fitted;
    logic [1:0]      sample_col;
    tpm_pins_s       pins;
    tpm_err_s        err;
    int              miscompares, cmp_count, cyc, t0, c, n;
    int              run[NCOL] = '{default: 0};
    int              plen[NCOL] = '{default: 0};
    int              pulses[NCOL] = '{default: 0};

    tpm_cart_model u_model (.clk_sys(clk_sys), .rstn(rstn), .fit(fit), .mem_ok(mem_ok), .spent(spent),
                            .full(full), .seal(seal), .motor(dispense_motor), .pins(pins));
    tpm_monitor #(.SLOT_CYC(SLOT), .DISP_CYC(DISP), .WAIT_CYC(WAIT)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .pins(pins), .door_closed(door_closed),
        .print_active(print_active), .dispense_motor(dispense_motor), .err(err),
        .toner_present(toner_present), .cart_fitted(cart_fitted), .check_busy(check_busy),
        .sample_stb(sample_stb), .sample_col(sample_col));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Measures the length and number of motor pulses per colour.
    always @(posedge clk_sys) begin
        cyc++;
        for (int k = 0; k < NCOL; k++) begin
            if (dispense_motor[k] === 1'b1) begin
                run[k]++;
            end else if (run[k] != 0) begin
                plen[k] = run[k];
                pulses[k]++;
                run[k] = 0;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic timeout;
        miscompares++;
        final_report();
    endtask : timeout

    task automatic next_stb;
        int k;
        k = 0;
        @(negedge clk_sys);
        while (sample_stb !== 1'b1) begin
            k++;
            if (k > 5 * SLOT) timeout();
            @(negedge clk_sys);
        end
    endtask : next_stb

    task automatic wait_stb(input logic [1:0] col);
        int k;
        k = 0;
        do begin
            next_stb();
            k++;
            if (k > 6) timeout();
        end while (sample_col !== col);
    endtask : wait_stb

    task automatic wait_pulses(input int col, input int cnt);
        int k;
        k = 0;
        while (pulses[col] < cnt) begin
            @(negedge clk_sys);
            k++;
            if (k > 3000) timeout();
        end
    endtask : wait_pulses

    initial begin
        {miscompares, cmp_count, cyc} = '0;
        {door_closed, print_active, rstn} = 3'h4;
        {fit, mem_ok, spent, seal} = '0;
        full = 4'hf;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(check_busy, 1);
        print_active = 1'b1;
        next_stb();
        check(sample_col, 0);
        t0 = cyc;
        for (c = 1; c < 8; c++) begin
            next_stb();
            check(sample_col, c % 4);
            check(cyc - t0, SLOT);
            t0 = cyc;
        end
        // Usage memory reports colour 1 empty.
        spent[1] = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(err.replace_colour, 4'h2);
        spent[1] = 1'b0;
        // Colour 2 still sealed: three misses end in the seal error.
        {fit[2], mem_ok[2], seal[2]} = 3'h7;
        wait_pulses(2, 1);
        check(plen[2], DISP);
        wait_stb(2);
        t0 = cyc;
        n = 0;
        while (dispense_motor[2] !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 100) timeout();
        end
        check((cyc - t0 >= WAIT) && (cyc - t0 <= WAIT + 2), 1);
        wait_pulses(2, 3);
        check(plen[2], DISP);
        wait_stb(2);
        repeat (2) @(negedge clk_sys);
        check(err.remove_seal, 4'h4);
        check({pulses[2], 3'(dispense_motor[2])}, 3 << 3);
        {fit[2], mem_ok[2]} = 2'h0;
        // Colour 0 fitted: actuator alone is not enough.
        fit[0] = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({cart_fitted[0], dispense_motor[0]}, 0);
        mem_ok[0] = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({cart_fitted[0], dispense_motor[0]}, 3);
        wait_pulses(0, 1);
        wait_stb(0);
        repeat (2) @(negedge clk_sys);
        check(err, 9'h0);
        check(toner_present[0], 0);
        n = 0;
        while (toner_present[0] !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 3000) timeout();
        end
        check(pulses[0], 3);
        // Cartridge 0 runs dry while idle.
        full[0] = 1'b0;
        wait_stb(0);
        repeat (2) @(negedge clk_sys);
        check({err.replace_general, toner_present[0]}, 2);
        // A fresh cartridge is ignored while the general error stands.
        {fit[3], mem_ok[3]} = 2'h3;
        repeat (20) @(negedge clk_sys);
        check(pulses[3] + dispense_motor[3], 0);
        // Door cycle restarts the rotation at the first colour.
        wait_stb(1);
        door_closed = 1'b0;
        repeat (4) @(negedge clk_sys);
        door_closed = 1'b1;
        next_stb();
        check(sample_col, 0);
        final_report();
    end
endmodule : test_toner_presence_monitor
